/* core/rx_fe_pkg.sv */
package rx_fe_pkg;
   // register offsets
   localparam logic [7:0] ADDR_LINK_TIMING_HIGH = 8'h04;
   localparam logic [7:0] ADDR_RX_FILTER_CONFIG = 8'h09;
   localparam logic [7:0] ADDR_RX_MIXER_GAIN = 8'h0a;
   localparam logic [7:0] ADDR_RF_OUTPUT_LO = 8'h0c;
   localparam logic [7:0] ADDR_MISC_ONE = 8'h0d;
   localparam logic [7:0] ADDR_MISC_TWO = 8'h0e;
   localparam logic [7:0] ADDR_MIXER_OPTION = 8'h22;
   localparam logic [7:0] ADDR_PAGED_STATUS = 8'h2c;
   // direct commands
   localparam logic [7:0] CMD_FILTER_CAL = 8'h88;
   localparam logic [7:0] CMD_TRIM_DOWN = 8'h89;
   localparam logic [7:0] CMD_TRIM_UP = 8'h8a;
   // field positions
   localparam int SINGLE_END_BIT = 0;
   localparam int TRIM_ADJ_EN_BIT = 0;
   localparam int LOAD_DOUBLE_BIT = 7;
   localparam int LOAD_HALF_BIT = 6;
   localparam int LO_SRC_BIT = 6;
   localparam int LO_BOOST_BIT = 7;
   localparam int PAGE_LSB = 6;
   localparam logic [1:0] PAGE_TRIM = 2'b10;
   // reset values and trim limits
   localparam logic [7:0] RESET_REG = 8'h00;
   localparam logic [3:0] TRIM_TYPICAL = 4'h8;
   localparam logic [3:0] TRIM_MAX = 4'hf;
   localparam logic [3:0] TRIM_MIN = 4'h0;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int CAL_TIME_MS = 5;
   localparam int CAL_CYCLES = CAL_TIME_MS * 1000 * CLK_MHZ;
   localparam int SETTLE_STEPS = 4;
   localparam int SETTLE_STEP_CYCLES = 64;

   typedef struct packed {
      logic [1:0] impedanceSel;
      logic [2:0] rangeSel;
      logic [2:0] loadCurrent;
      logic loadDouble;
      logic loadExtraHalf;
      logic singleEndOn;
   } mixer_cfg_s;

   typedef struct packed {
      logic [2:0] highPassCorner;
      logic [2:0] lowPassCorner;
      logic skipOne;
      logic skipTwo;
      logic [3:0] highPassTrim;
      logic [3:0] lowPassTrim;
   } filter_cfg_s;

   typedef struct packed {
      logic fromPreAmp;
      logic boost;
   } lo_cfg_s;
endpackage : rx_fe_pkg

/* core/reg_store.sv */
`timescale 1ns/1ps
`default_nettype none
// small register memory with registered read data
module reg_store (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // write port
   input wire logic writeEn,
   input wire logic [5:0] writeAddr,
   input wire logic [7:0] writeData,
   // read port
   input wire logic [5:0] readAddr,
   output logic [7:0] readData
);
   logic [7:0] mem [64];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 64; i++) begin
            mem[i] <= rx_fe_pkg::RESET_REG;
         end
      end else if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         readData <= rx_fe_pkg::RESET_REG;
      end else begin
         readData <= mem[readAddr];
      end
   end
endmodule : reg_store
`default_nettype wire

/* core/rx_frontend_filter_cal_ctrl.sv */
// Notes on behaviour
// - the single-ended mixer stays off unless its enable bit in misc control one is set.
// - the two-bit impedance field of the mixer gain register drives mixer impedance and gain.
// - the three-bit range field of the mixer option register drives mixer input range.
// - load current comes from the double and extra-half bits plus the three-bit load field.
// - bit 6 of the lo path control picks RF output pins or the pre-amplifier as LO source.
// - bit 7 of the lo path control raises LO drive by about six decibels.
// - DC points are held from modulation start and the high-pass constant steps after tx ends.
// - the filter config register sets both corners and the two stage bypass bits.
// - the calibration command starts a filter calibration that ends within 5 ms.
// - trims read back in the paged status register on page 10b, typically as 88h.
// - trim up and down commands act only when trim adjust enable is already set.
// - each trim drives only its own side of the filter, in steps of about four percent.
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_filter_cal_ctrl #(
   parameter int CAL_CYCLES = rx_fe_pkg::CAL_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register access from the host port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWriteData,
   output logic [7:0] regReadData,
   output logic regReadValid,
   // direct commands from the host port
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   // transmit timing from the tx chain
   input wire logic txModulating,
   // analog control outputs
   output rx_fe_pkg::mixer_cfg_s mixerCfg,
   output rx_fe_pkg::filter_cfg_s filterCfg,
   output rx_fe_pkg::lo_cfg_s loCfg,
   output logic dcHold,
   output logic [1:0] hpSettleStep,
   output logic calBusy
);
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_RUN = 3'b010,
      CAL_DONE = 3'b100
   } cal_state_e;

   typedef enum logic [2:0] {
      AC_TRACK = 3'b001,
      AC_HOLD = 3'b010,
      AC_SETTLE = 3'b100
   } ac_state_e;

   cal_state_e calState;
   ac_state_e acState;
   logic [31:0] calCount;
   logic [7:0] settleCount;
   logic [2:0] settleIdx;
   logic [3:0] hpTrim;
   logic [3:0] lpTrim;
   logic [7:0] linkTimingHigh;
   logic [7:0] filterReg;
   logic [7:0] mixerGainReg;
   logic [7:0] loReg;
   logic [7:0] miscOne;
   logic [7:0] miscTwo;
   logic [7:0] mixerOptReg;
   logic [7:0] storeData;
   logic readPending;
   logic readIsStatus;
   logic readIsShadow;
   logic [7:0] shadowRead;
   logic txSeen;

   function automatic logic addrIs(input logic [5:0] a, input logic [7:0] off);
      addrIs = (a == off[5:0]);
   endfunction : addrIs

   function automatic logic [3:0] trimStep(input logic [3:0] t, input logic up);
      // saturate rather than wrap: a wrap would jump the corner by sixty percent
      if (up) begin
         trimStep = (t == rx_fe_pkg::TRIM_MAX) ? t : 4'(t + 4'h1);
      end else begin
         trimStep = (t == rx_fe_pkg::TRIM_MIN) ? t : 4'(t - 4'h1);
      end
   endfunction : trimStep

   // unmapped addresses fall through to the general store
   reg_store store (
      .core_clk(core_clk),
      .rst(rst),
      .writeEn(regWrite),
      .writeAddr(regAddr),
      .writeData(regWriteData),
      .readAddr(regAddr),
      .readData(storeData)
   );

   // named control registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         linkTimingHigh <= rx_fe_pkg::RESET_REG;
         filterReg <= rx_fe_pkg::RESET_REG;
         mixerGainReg <= rx_fe_pkg::RESET_REG;
         loReg <= rx_fe_pkg::RESET_REG;
         miscOne <= rx_fe_pkg::RESET_REG;
         miscTwo <= rx_fe_pkg::RESET_REG;
         mixerOptReg <= rx_fe_pkg::RESET_REG;
      end else if (regWrite) begin
         if (addrIs(regAddr, rx_fe_pkg::ADDR_LINK_TIMING_HIGH)) begin
            linkTimingHigh <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_RX_FILTER_CONFIG)) begin
            filterReg <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_RX_MIXER_GAIN)) begin
            mixerGainReg <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_RF_OUTPUT_LO)) begin
            loReg <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_MISC_ONE)) begin
            miscOne <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_MISC_TWO)) begin
            miscTwo <= regWriteData;
         end
         if (addrIs(regAddr, rx_fe_pkg::ADDR_MIXER_OPTION)) begin
            mixerOptReg <= regWriteData;
         end
      end
   end

   // mixer and lo outputs
   // registered so the analog side never sees a decode glitch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mixerCfg <= '0;
         loCfg <= '0;
      end else begin
         mixerCfg.singleEndOn <= miscOne[rx_fe_pkg::SINGLE_END_BIT];
         mixerCfg.impedanceSel <= mixerGainReg[7:6];
         mixerCfg.rangeSel <= mixerOptReg[2:0];
         mixerCfg.loadCurrent <= mixerOptReg[5:3];
         mixerCfg.loadDouble <= linkTimingHigh[rx_fe_pkg::LOAD_DOUBLE_BIT];
         mixerCfg.loadExtraHalf <= linkTimingHigh[rx_fe_pkg::LOAD_HALF_BIT];
         loCfg.fromPreAmp <= loReg[rx_fe_pkg::LO_SRC_BIT];
         loCfg.boost <= loReg[rx_fe_pkg::LO_BOOST_BIT];
      end
   end

   // filter outputs; each trim feeds only its own side
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         filterCfg <= '0;
      end else begin
         filterCfg.highPassCorner <= filterReg[3:1];
         filterCfg.lowPassCorner <= filterReg[7:5];
         filterCfg.skipOne <= filterReg[0];
         filterCfg.skipTwo <= filterReg[4];
         filterCfg.highPassTrim <= hpTrim;
         filterCfg.lowPassTrim <= lpTrim;
      end
   end

   // calibration sequencer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         calState <= CAL_IDLE;
         calCount <= '0;
      end else begin
         unique case (calState)
            CAL_IDLE: begin
               if (cmdValid && cmdCode == rx_fe_pkg::CMD_FILTER_CAL) begin
                  calState <= CAL_RUN;
                  calCount <= '0;
               end
            end
            CAL_RUN: begin
               // leave one count early: busy then spans CAL_CYCLES clocks, not one more
               if (calCount >= 32'(CAL_CYCLES - 2)) begin
                  calState <= CAL_DONE;
               end else begin
                  calCount <= calCount + 32'h0000_0001;
               end
            end
            CAL_DONE: begin
               calState <= CAL_IDLE;
            end
            default: begin
               calState <= CAL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         calBusy <= 1'b0;
      end else begin
         calBusy <= (calState == CAL_RUN) ||
            (calState == CAL_IDLE && cmdValid && cmdCode == rx_fe_pkg::CMD_FILTER_CAL);
      end
   end

   // trims: calibration lands on the typical code; no analog sense to converge on here
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hpTrim <= rx_fe_pkg::TRIM_TYPICAL;
         lpTrim <= rx_fe_pkg::TRIM_TYPICAL;
      end else if (calState == CAL_DONE) begin
         hpTrim <= rx_fe_pkg::TRIM_TYPICAL;
         lpTrim <= rx_fe_pkg::TRIM_TYPICAL;
      end else if (cmdValid && calState == CAL_IDLE &&
            miscTwo[rx_fe_pkg::TRIM_ADJ_EN_BIT]) begin
         // refused during a calibration so the result is not disturbed
         if (cmdCode == rx_fe_pkg::CMD_TRIM_UP) begin
            hpTrim <= trimStep(hpTrim, 1'b1);
            lpTrim <= trimStep(lpTrim, 1'b1);
         end else if (cmdCode == rx_fe_pkg::CMD_TRIM_DOWN) begin
            hpTrim <= trimStep(hpTrim, 1'b0);
            lpTrim <= trimStep(lpTrim, 1'b0);
         end
      end
   end

   // fast ac coupling: track, hold during tx, then stepped settle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acState <= AC_TRACK;
         settleCount <= '0;
         settleIdx <= '0;
         txSeen <= 1'b0;
      end else begin
         // delayed copy turns the tx level into a start edge
         txSeen <= txModulating;
         unique case (acState)
            AC_TRACK: begin
               if (txModulating && !txSeen) begin
                  acState <= AC_HOLD;
               end
            end
            AC_HOLD: begin
               if (!txModulating) begin
                  acState <= AC_SETTLE;
                  settleCount <= '0;
                  settleIdx <= '0;
               end
            end
            AC_SETTLE: begin
               if (txModulating) begin
                  acState <= AC_HOLD;
               end else if (settleCount == 8'(rx_fe_pkg::SETTLE_STEP_CYCLES - 1)) begin
                  settleCount <= '0;
                  if (settleIdx == 3'(rx_fe_pkg::SETTLE_STEPS - 1)) begin
                     acState <= AC_TRACK;
                  end else begin
                     settleIdx <= settleIdx + 3'h1;
                  end
               end else begin
                  settleCount <= settleCount + 8'h01;
               end
            end
            default: begin
               acState <= AC_TRACK;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dcHold <= 1'b0;
         hpSettleStep <= '0;
      end else begin
         dcHold <= (acState == AC_HOLD);
         // code 3 is the slowest constant, i.e. plain tracking
         hpSettleStep <= (acState == AC_SETTLE) ? settleIdx[1:0] : 2'h3;
      end
   end

   // read path: one cycle to the store and shadow mux, one to output
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         readPending <= 1'b0;
         readIsStatus <= 1'b0;
         readIsShadow <= 1'b0;
         shadowRead <= '0;
      end else begin
         readPending <= regRead;
         readIsStatus <= addrIs(regAddr, rx_fe_pkg::ADDR_PAGED_STATUS);
         readIsShadow <= 1'b1;
         if (addrIs(regAddr, rx_fe_pkg::ADDR_LINK_TIMING_HIGH)) begin
            shadowRead <= linkTimingHigh;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_RX_FILTER_CONFIG)) begin
            shadowRead <= filterReg;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_RX_MIXER_GAIN)) begin
            shadowRead <= mixerGainReg;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_RF_OUTPUT_LO)) begin
            shadowRead <= loReg;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_MISC_ONE)) begin
            shadowRead <= miscOne;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_MISC_TWO)) begin
            shadowRead <= miscTwo;
         end else if (addrIs(regAddr, rx_fe_pkg::ADDR_MIXER_OPTION)) begin
            shadowRead <= mixerOptReg;
         end else begin
            readIsShadow <= 1'b0;
         end
      end
   end

   // status page other than trims reads zero: those sources live elsewhere
   // the page bits sit in the store, so paging costs no extra register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regReadData <= '0;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= readPending;
         if (!readPending) begin
            regReadData <= regReadData;
         end else if (readIsStatus) begin
            regReadData <= (storeData[rx_fe_pkg::PAGE_LSB +: 2] == rx_fe_pkg::PAGE_TRIM) ?
               {lpTrim, hpTrim} : 8'h00;
         end else if (readIsShadow) begin
            regReadData <= shadowRead;
         end else begin
            regReadData <= storeData;
         end
      end
   end
endmodule : rx_frontend_filter_cal_ctrl
`default_nettype wire

/* bench/rx_fe_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_fe_asserts #(
   parameter int CAL_CYCLES = 20
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host side
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   input wire logic txModulating,
   // analog side
   input wire rx_fe_pkg::mixer_cfg_s mixerCfg,
   input wire rx_fe_pkg::filter_cfg_s filterCfg,
   input wire rx_fe_pkg::lo_cfg_s loCfg,
   input wire logic dcHold,
   input wire logic [1:0] hpSettleStep,
   input wire logic calBusy
);
   // shadow of the trim enable, since the checker sees only the ports
   logic trimEn;
   int busyCnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) trimEn <= 1'b0;
      else if (regWrite && regAddr == 6'h0e) trimEn <= regWriteData[0];
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) busyCnt <= 0;
      else busyCnt <= calBusy ? busyCnt + 1 : 0;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   single_end_a: assert property (regWrite && regAddr == 6'h0d |->
      ##2 mixerCfg.singleEndOn == $past(regWriteData[0], 2)) else $error("single end bit");
   impedance_sel_a: assert property (regWrite && regAddr == 6'h0a |->
      ##2 mixerCfg.impedanceSel == $past(regWriteData[7:6], 2)) else $error("impedance");
   filter_cfg_a: assert property (regWrite && regAddr == 6'h09 |-> ##2
      {filterCfg.lowPassCorner, filterCfg.skipTwo, filterCfg.highPassCorner,
      filterCfg.skipOne} == $past(regWriteData, 2)) else $error("filter config");
   lo_path_a: assert property (regWrite && regAddr == 6'h0c |->
      ##2 {loCfg.boost, loCfg.fromPreAmp} == $past(regWriteData[7:6], 2)) else $error("lo path");
   cal_start_a: assert property (cmdValid && cmdCode == 8'h88 && !calBusy |=> calBusy)
      else $error("cal not started");
   cal_bound_a: assert property (busyCnt <= CAL_CYCLES) else $error("cal too long");
   trim_up_a: assert property (cmdValid && cmdCode == 8'h8a && trimEn && !calBusy |->
      ##2 filterCfg.highPassTrim == ($past(filterCfg.highPassTrim, 2) == 4'hf ? 4'hf :
      $past(filterCfg.highPassTrim, 2) + 4'h1)) else $error("trim up");
   trim_hold_a: assert property ((cmdCode == 8'h89 || cmdCode == 8'h8a) && cmdValid &&
      !trimEn && !calBusy |-> ##2 {filterCfg.highPassTrim, filterCfg.lowPassTrim} ==
      $past({filterCfg.highPassTrim, filterCfg.lowPassTrim}, 2)) else $error("trim moved");
   dc_hold_a: assert property ($rose(txModulating) |-> ##[2:3] dcHold)
      else $error("dc points not held");
   read_valid_a: assert property (regRead |-> ##2 regReadValid) else $error("read answer");
endmodule : rx_fe_asserts
bind rx_frontend_filter_cal_ctrl rx_fe_asserts #(.CAL_CYCLES(CAL_CYCLES)) chk_u (
   .core_clk(core_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
   .regReadValid(regReadValid), .cmdValid(cmdValid), .cmdCode(cmdCode),
   .txModulating(txModulating), .mixerCfg(mixerCfg), .filterCfg(filterCfg),
   .loCfg(loCfg), .dcHold(dcHold), .hpSettleStep(hpSettleStep), .calBusy(calBusy));
`default_nettype wire

/* bench/host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   // clock
   input wire logic core_clk,
   // requests
   output logic regWrite,
   output logic regRead,
   output logic [5:0] regAddr,
   output logic [7:0] regWriteData,
   output logic cmdValid,
   output logic [7:0] cmdCode,
   // answers
   input wire logic [7:0] regReadData,
   input wire logic regReadValid
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 6'h00;
      regWriteData = 8'h00;
      cmdValid = 1'b0;
      cmdCode = 8'h00;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWriteData <= ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         if (regReadValid === 1'b1) begin
            d = regReadData;
            break;
         end
      end
   endtask : rd
   // commands are driven for one cycle; trim codes may be sent while the enable is still clear
   task automatic cmd(input logic [7:0] c);
      @(posedge core_clk);
      cmdValid <= 1'b1;
      cmdCode <= c;
      @(posedge core_clk);
      cmdValid <= 1'b0;
      cmdCode <= ~c;
   endtask : cmd
endmodule : host_port_model
`default_nettype wire

/* bench/tb_rx_frontend_filter_cal_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rx_frontend_filter_cal_ctrl;
   localparam int CALC = 20;
   logic core_clk, rst, regWrite, regRead, regReadValid, cmdValid, txModulating;
   logic dcHold, calBusy;
   logic [5:0] regAddr, a;
   logic [7:0] regWriteData, regReadData, cmdCode, d, r;
   logic [1:0] hpSettleStep;
   logic [3:0] t;
   rx_fe_pkg::mixer_cfg_s mixerCfg;
   rx_fe_pkg::filter_cfg_s filterCfg;
   rx_fe_pkg::lo_cfg_s loCfg;
   int n_mismatch = 0, total_checks = 0, cycles = 0, n;
   logic [5:0] addrs [8] = '{6'h04, 6'h09, 6'h0a, 6'h0c, 6'h0d, 6'h0e, 6'h22, 6'h3a};
   logic [7:0] linkModes [3] = '{8'h04, 8'h3f, 8'hff};
   rx_frontend_filter_cal_ctrl #(.CAL_CYCLES(CALC)) dut_u (
      .core_clk(core_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
      .regReadValid(regReadValid), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .txModulating(txModulating), .mixerCfg(mixerCfg), .filterCfg(filterCfg),
      .loCfg(loCfg), .dcHold(dcHold), .hpSettleStep(hpSettleStep), .calBusy(calBusy));
   host_port_model host_u (
      .core_clk(core_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWriteData(regWriteData), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .regReadData(regReadData), .regReadValid(regReadValid));
   // register image rebuilt from the analog outputs
   function automatic logic [7:0] obs(input logic [5:0] a);
      case (a)
         6'h04: obs = {mixerCfg.loadDouble, mixerCfg.loadExtraHalf, 6'h00};
         6'h09: obs = {filterCfg.lowPassCorner, filterCfg.skipTwo, filterCfg.highPassCorner,
            filterCfg.skipOne};
         6'h0a: obs = {mixerCfg.impedanceSel, 6'h00};
         6'h0c: obs = {loCfg.boost, loCfg.fromPreAmp, 6'h00};
         6'h0d: obs = {7'h00, mixerCfg.singleEndOn};
         6'h22: obs = {2'h0, mixerCfg.loadCurrent, mixerCfg.rangeSel};
         default: obs = 8'h00;
      endcase
   endfunction : obs
   function automatic logic [7:0] mask(input logic [5:0] a);
      case (a)
         6'h04, 6'h0a, 6'h0c: mask = 8'hc0;
         6'h09: mask = 8'hff;
         6'h0d: mask = 8'h01;
         6'h22: mask = 8'h3f;
         default: mask = 8'h00;
      endcase
   endfunction : mask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // the whole run takes some 1000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      txModulating = 1'b0;
      void'($urandom(32'h70a89a2a));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      cyc(2);
      chk({5'h00, mixerCfg.singleEndOn, calBusy, dcHold}, 8'h00);
      for (int i = 0; i < 40; i++) begin
         a = (i < 3) ? 6'h09 : addrs[i % 8];
         d = (i < 3) ? linkModes[i] : 8'($urandom);
         host_u.wr(a, d);
         cyc(2);
         chk(obs(a), d & mask(a));
         host_u.rd(a, r);
         chk(r, d);
      end
      $display("register test done");
      host_u.wr(6'h0e, 8'h00);
      host_u.wr(6'h2c, 8'h80);
      host_u.rd(6'h2c, r);
      chk(r, 8'h88);
      host_u.cmd(8'h88);
      cyc(1);
      chk({7'h00, calBusy}, 8'h01);
      host_u.cmd(8'h88);
      host_u.cmd(8'h8a);
      n = 0;
      while (calBusy === 1'b1 && n < CALC + 10) begin
         @(posedge core_clk);
         n++;
      end
      chk({7'h00, n <= CALC}, 8'h01);
      cyc(3);
      chk({filterCfg.highPassTrim, filterCfg.lowPassTrim}, 8'h88);
      $display("calibration test done");
      host_u.cmd(8'h8a);
      cyc(3);
      chk({filterCfg.highPassTrim, filterCfg.lowPassTrim}, 8'h88);
      host_u.wr(6'h0e, 8'h01);
      t = 4'h8;
      for (int i = 0; i < 36; i++) begin
         d = (i < 9) ? 8'h8a : (i < 27) ? 8'h89 : (($urandom % 2) ? 8'h8a : 8'h89);
         host_u.cmd(d);
         if (d == 8'h8a) t = (t == 4'hf) ? t : t + 4'h1;
         else t = (t == 4'h0) ? t : t - 4'h1;
         cyc(3);
         chk({filterCfg.highPassTrim, filterCfg.lowPassTrim}, {t, t});
      end
      host_u.rd(6'h2c, r);
      chk(r, {t, t});
      host_u.cmd(8'h88);
      cyc(CALC + 3);
      chk({filterCfg.highPassTrim, filterCfg.lowPassTrim}, 8'h88);
      $display("trim test done");
      @(posedge core_clk);
      txModulating <= 1'b1;
      repeat ($urandom_range(5, 40)) @(posedge core_clk);
      chk({7'h00, dcHold}, 8'h01);
      txModulating <= 1'b0;
      cyc(3);
      chk({5'h00, dcHold, hpSettleStep}, 8'h00);
      cyc(96);
      chk({6'h00, hpSettleStep}, 8'h01);
      @(posedge core_clk);
      txModulating <= 1'b1;
      cyc(4);
      chk({7'h00, dcHold}, 8'h01);
      @(posedge core_clk);
      txModulating <= 1'b0;
      cyc(300);
      chk({5'h00, dcHold, hpSettleStep}, 8'h03);
      $display("ac coupling test done");
      conclude();
   end
endmodule : tb_rx_frontend_filter_cal_ctrl
`default_nettype wire
